/* File: common/cms_cfg.svh */
// register map, field positions, reset values and timing counts
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// ==========================================================
// register byte offsets
`define CMS_OFF_CTRL_ONE 4'h0
`define CMS_OFF_CTRL_TWO 4'h4
`define CMS_OFF_CTRL_THREE 4'h8
`define CMS_OFF_STATUS 4'hC

// ==========================================================
// control one fields
`define CMS_C1_CLOCK_SOURCE_SELECT_HI 7
`define CMS_C1_CLOCK_SOURCE_SELECT_LO 6
`define CMS_C1_REFERENCE_DIVIDER_HI 5
`define CMS_C1_REFERENCE_DIVIDER_LO 3
`define CMS_C1_INTERNAL_REFERENCE_SELECT 2
`define CMS_C1_INTERNAL_REFERENCE_ENABLE 1
// control two fields
`define CMS_C2_BUS_DIVIDER_HI 7
`define CMS_C2_BUS_DIVIDER_LO 6
`define CMS_C2_RANGE 5
`define CMS_C2_HGO 4
`define CMS_C2_LP 3
`define CMS_C2_CRYSTAL_SELECT 2
`define CMS_C2_EXTERNAL_REFERENCE_ENABLE 1
// control three fields
`define CMS_C3_PLL_SELECT 6
`define CMS_C3_PLL_MULTIPLIER_HI 3
`define CMS_C3_PLL_MULTIPLIER_LO 0
// status fields
`define CMS_SC_LOCK 6
`define CMS_SC_PLL_SELECT_STATUS 5
`define CMS_SC_IREFST 4
`define CMS_SC_CLOCK_SOURCE_STATUS_HI 3
`define CMS_SC_CLOCK_SOURCE_STATUS_LO 2
`define CMS_SC_OSCILLATOR_INITIALIZED 1

// ==========================================================
// reset values
`define CMS_RST_CTRL_ONE 8'h04
`define CMS_RST_CTRL_TWO 8'h40
`define CMS_RST_CTRL_THREE 8'h01

// ==========================================================
// loop factors and timing counts in clk cycles
`define CMS_FLL_SHIFT 10
`define CMS_PLL_MULTIPLIER_SHIFT 2
`define CMS_OSC_STARTUP_CYCLES 64
`define CMS_LOCK_CYCLES 32
`define CMS_IREF_STABLE_CYCLES 16

// axi responses
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2

`endif

/* File: common/cms_pkg.sv */
// types shared by the clock mode sequencer
`default_nettype none
package cms_pkg;
  // operating modes of the generator
  typedef enum logic [2:0] {
    MODE_LOOP_ENGAGED_INTERNAL = 3'b000,
    MODE_LOOP_ENGAGED_EXTERNAL = 3'b001,
    MODE_LOOP_BYPASSED_EXTERNAL = 3'b010,
    MODE_LOOP_BYPASSED_INTERNAL = 3'b011,
    MODE_PLL_ENGAGED_EXTERNAL = 3'b100,
    MODE_PLL_BYPASSED_EXTERNAL = 3'b101,
    MODE_LOW_POWER_INTERNAL = 3'b110,
    MODE_LOW_POWER_EXTERNAL = 3'b111
  } cms_mode_e;
  // source status code
  typedef logic [1:0] cms_src_t;
endpackage : cms_pkg
`default_nettype wire

/* File: hdl/clock_mode_sequencer.sv */
// clock mode sequencer: mode decode, switching, status and axi registers
// Overview of operation
// - reset enters fll internal; three direct exits
// - clock_source_select 00, internal_reference_select 0: fll on external, pll on external with pll select bit set
// - clock_source_select 10, internal_reference_select 0: external, fll locks unless the pll select or low power bit is set
// - clock_source_select 01 routes internal reference out
// - status 3:2 reports actual output source
// - oscillator initialized after crystal startup count
// - each committed mode change between non low power modes shows in status
// - status bit 4 reports reference source
// - status bit 5 reports pll selected
// - status bit 6 shows selected loop lock
// - output frequency follows mode formula
// - bus clock is half output clock
// - control two field layout
// - control one field layout
// - control three field layout
// - low power bit disables both loops with clock_source_select 01 or 10 only
// - internal enable bit is writable, so the internal reference also keeps running outside internal modes while it is set
// - unavailable clock keeps previous source
`include "cms_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module clock_mode_sequencer #(
  parameter int OSC_STARTUP_CYCLES = `CMS_OSC_STARTUP_CYCLES,
  parameter int LOCK_CYCLES = `CMS_LOCK_CYCLES,
  parameter int IREF_STABLE_CYCLES = `CMS_IREF_STABLE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic extRefPresent,
  input wire logic [31:0] extRefFreq,
  input wire logic [31:0] intRefFreq,
  output cms_pkg::cms_mode_e clockMode,
  output logic [31:0] genOutFreq,
  output logic [31:0] busFreq,
  output logic fllEnable,
  output logic pllEnable,
  output logic intRefOn,
  output logic oscEnable,
  output logic oscHighRange,
  output logic oscHighGain
);
  import cms_pkg::*;

  localparam int OSC_W = $clog2(OSC_STARTUP_CYCLES + 1);
  localparam int LCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int IRS_W = $clog2(IREF_STABLE_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_MAX = OSC_W'(OSC_STARTUP_CYCLES);
  localparam logic [LCK_W-1:0] LCK_MAX = LCK_W'(LOCK_CYCLES);
  localparam logic [IRS_W-1:0] IRS_MAX = IRS_W'(IREF_STABLE_CYCLES);

  // ========================================================
  // helper functions

  // modes fed from the internal reference
  function automatic logic isInternal(input cms_mode_e m);
    isInternal = (m == MODE_LOOP_ENGAGED_INTERNAL) ||
      (m == MODE_LOOP_BYPASSED_INTERNAL) || (m == MODE_LOW_POWER_INTERNAL);
  endfunction : isInternal

  // modes with both loops shut down
  function automatic logic isLowPower(input cms_mode_e m);
    isLowPower = (m == MODE_LOW_POWER_INTERNAL) ||
      (m == MODE_LOW_POWER_EXTERNAL);
  endfunction : isLowPower

  // modes running the pll
  function automatic logic usesPll(input cms_mode_e m);
    usesPll = (m == MODE_PLL_ENGAGED_EXTERNAL) ||
      (m == MODE_PLL_BYPASSED_EXTERNAL);
  endfunction : usesPll

  // source status code of a mode
  function automatic cms_src_t srcOf(input cms_mode_e m);
    unique case (m)
      MODE_LOOP_ENGAGED_INTERNAL, MODE_LOOP_ENGAGED_EXTERNAL: srcOf = 2'h0;
      MODE_LOOP_BYPASSED_INTERNAL, MODE_LOW_POWER_INTERNAL: srcOf = 2'h1;
      MODE_PLL_ENGAGED_EXTERNAL: srcOf = 2'h3;
      MODE_LOOP_BYPASSED_EXTERNAL, MODE_PLL_BYPASSED_EXTERNAL,
      MODE_LOW_POWER_EXTERNAL: srcOf = 2'h2;
    endcase
  endfunction : srcOf

  // direct steps allowed between modes
  function automatic logic legalStep(input cms_mode_e c, input cms_mode_e r);
    unique case (c)
      MODE_LOOP_ENGAGED_INTERNAL: legalStep = r inside {
        MODE_LOOP_ENGAGED_EXTERNAL, MODE_LOOP_BYPASSED_EXTERNAL,
        MODE_LOOP_BYPASSED_INTERNAL};
      MODE_LOOP_ENGAGED_EXTERNAL: legalStep = r inside {
        MODE_LOOP_ENGAGED_INTERNAL, MODE_LOOP_BYPASSED_EXTERNAL,
        MODE_LOOP_BYPASSED_INTERNAL};
      MODE_LOOP_BYPASSED_INTERNAL: legalStep = r inside {
        MODE_LOOP_ENGAGED_INTERNAL, MODE_LOOP_ENGAGED_EXTERNAL,
        MODE_LOOP_BYPASSED_EXTERNAL, MODE_LOW_POWER_INTERNAL};
      MODE_LOOP_BYPASSED_EXTERNAL: legalStep = r inside {
        MODE_LOOP_ENGAGED_INTERNAL, MODE_LOOP_ENGAGED_EXTERNAL,
        MODE_LOOP_BYPASSED_INTERNAL, MODE_PLL_BYPASSED_EXTERNAL,
        MODE_LOW_POWER_EXTERNAL};
      MODE_PLL_BYPASSED_EXTERNAL: legalStep = r inside {
        MODE_LOOP_BYPASSED_EXTERNAL, MODE_PLL_ENGAGED_EXTERNAL,
        MODE_LOW_POWER_EXTERNAL};
      MODE_PLL_ENGAGED_EXTERNAL: legalStep = (r == MODE_PLL_BYPASSED_EXTERNAL);
      MODE_LOW_POWER_INTERNAL: legalStep = (r == MODE_LOOP_BYPASSED_INTERNAL);
      MODE_LOW_POWER_EXTERNAL: legalStep = r inside {
        MODE_LOOP_BYPASSED_EXTERNAL, MODE_PLL_BYPASSED_EXTERNAL};
    endcase
  endfunction : legalStep

  // ========================================================
  // register file and axi4-lite slave
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic [7:0] ctrlThree;
  logic [7:0] statusReg;
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddrQ;
  logic [7:0] wDataQ;
  logic wStrbQ;
  logic doWrite;

  // channel readies drop while an item or a response is pending
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // address and data capture, in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 8'h00;
      wStrbQ <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= {s_axi_awaddr[3:2], 2'h0};
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata[7:0];
        wStrbQ <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped upper addresses get slverr
  logic awMapped;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awMapped <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awMapped <= (s_axi_awaddr[31:4] == 28'h0000000);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= awMapped ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers, low byte lane only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlOne <= `CMS_RST_CTRL_ONE;
      ctrlTwo <= `CMS_RST_CTRL_TWO;
      ctrlThree <= `CMS_RST_CTRL_THREE;
    end else if (doWrite && wStrbQ && awMapped) begin
      unique case (awAddrQ)
        `CMS_OFF_CTRL_ONE: ctrlOne <= {wDataQ[7:1], 1'b0};
        `CMS_OFF_CTRL_TWO: ctrlTwo <= {wDataQ[7:1], 1'b0};
        `CMS_OFF_CTRL_THREE: ctrlThree <= {1'b0, wDataQ[6], 2'h0,
          wDataQ[3:0]};
        default: ;
      endcase
    end
  end

  // read channel, answers one cycle after the address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CMS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr[31:4] != 28'h0000000) begin
        s_axi_rresp <= `CMS_RESP_SLVERR;
      end else begin
        unique case ({s_axi_araddr[3:2], 2'h0})
          `CMS_OFF_CTRL_ONE: s_axi_rdata <= {24'h000000, ctrlOne};
          `CMS_OFF_CTRL_TWO: s_axi_rdata <= {24'h000000, ctrlTwo};
          `CMS_OFF_CTRL_THREE: s_axi_rdata <= {24'h000000, ctrlThree};
          `CMS_OFF_STATUS: s_axi_rdata <= {24'h000000, statusReg};
          default: ;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================
  // control fields
  logic [1:0] clkSel;
  logic [2:0] refDiv;
  logic irefSel;
  logic irefEnable;
  logic [1:0] busDiv;
  logic lowPowerBit;
  logic crystalSel;
  logic extEnable;
  logic pllSel;
  logic [3:0] pllMult;
  assign clkSel = ctrlOne[`CMS_C1_CLOCK_SOURCE_SELECT_HI:`CMS_C1_CLOCK_SOURCE_SELECT_LO];
  assign refDiv = ctrlOne[`CMS_C1_REFERENCE_DIVIDER_HI:`CMS_C1_REFERENCE_DIVIDER_LO];
  assign irefSel = ctrlOne[`CMS_C1_INTERNAL_REFERENCE_SELECT];
  assign irefEnable = ctrlOne[`CMS_C1_INTERNAL_REFERENCE_ENABLE];
  assign busDiv = ctrlTwo[`CMS_C2_BUS_DIVIDER_HI:`CMS_C2_BUS_DIVIDER_LO];
  assign lowPowerBit = ctrlTwo[`CMS_C2_LP];
  assign crystalSel = ctrlTwo[`CMS_C2_CRYSTAL_SELECT];
  assign extEnable = ctrlTwo[`CMS_C2_EXTERNAL_REFERENCE_ENABLE];
  assign pllSel = ctrlThree[`CMS_C3_PLL_SELECT];
  assign pllMult = ctrlThree[`CMS_C3_PLL_MULTIPLIER_HI:`CMS_C3_PLL_MULTIPLIER_LO];
  assign oscHighRange = ctrlTwo[`CMS_C2_RANGE];
  assign oscHighGain = ctrlTwo[`CMS_C2_HGO];

  // ========================================================
  // mode decode and switching
  cms_mode_e curMode;
  cms_mode_e reqMode;
  logic modeReady;
  logic commit;
  logic extAvail;
  logic intStable;
  logic lockQ;
  logic pll_select_status;

  // requested mode from the control bits; reserved clock_source_select keeps the mode
  always_comb begin
    reqMode = curMode;
    unique case (clkSel)
      2'h0: reqMode = irefSel ? MODE_LOOP_ENGAGED_INTERNAL :
        (pllSel ? MODE_PLL_ENGAGED_EXTERNAL :
        MODE_LOOP_ENGAGED_EXTERNAL);
      2'h1: reqMode = lowPowerBit ? MODE_LOW_POWER_INTERNAL :
        MODE_LOOP_BYPASSED_INTERNAL;
      2'h2: reqMode = lowPowerBit ? MODE_LOW_POWER_EXTERNAL :
        (pllSel ? MODE_PLL_BYPASSED_EXTERNAL :
        MODE_LOOP_BYPASSED_EXTERNAL);
      2'h3: reqMode = curMode;
    endcase
  end

  // target clock must be up before the switch
  always_comb begin
    unique case (reqMode)
      MODE_LOOP_ENGAGED_INTERNAL, MODE_LOOP_BYPASSED_INTERNAL,
      MODE_LOW_POWER_INTERNAL: modeReady = intStable;
      MODE_PLL_ENGAGED_EXTERNAL: modeReady = extAvail && pll_select_status && lockQ;
      MODE_LOOP_ENGAGED_EXTERNAL, MODE_LOOP_BYPASSED_EXTERNAL,
      MODE_PLL_BYPASSED_EXTERNAL,
      MODE_LOW_POWER_EXTERNAL: modeReady = extAvail;
    endcase
  end

  assign commit = (reqMode != curMode) && legalStep(curMode, reqMode) &&
    modeReady;

  // current mode register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      curMode <= MODE_LOOP_ENGAGED_INTERNAL;
    end else if (commit) begin
      curMode <= reqMode;
    end
  end

  assign clockMode = curMode;
  assign fllEnable = !isLowPower(curMode) && !usesPll(curMode);
  assign pllEnable = usesPll(curMode);
  assign intRefOn = isInternal(curMode) || irefEnable;

  // ========================================================
  // oscillator startup and internal reference settling
  logic oscRun;
  logic oscillator_initialized;
  logic [OSC_W-1:0] oscCnt;
  logic [IRS_W-1:0] irsCnt;
  assign oscRun = crystalSel && (extEnable || !isInternal(curMode) ||
    !isInternal(reqMode));
  assign oscEnable = oscRun;
  assign extAvail = crystalSel ? oscillator_initialized : extRefPresent;

  // crystal startup counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscCnt <= '0;
      oscillator_initialized <= 1'b0;
    end else if (!oscRun) begin
      oscCnt <= '0;
      oscillator_initialized <= 1'b0;
    end else if (oscCnt != OSC_MAX) begin
      oscCnt <= oscCnt + OSC_W'(1);
    end else begin
      oscillator_initialized <= 1'b1;
    end
  end

  // internal reference settling counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irsCnt <= '0;
    end else if (!intRefOn) begin
      irsCnt <= '0;
    end else if (irsCnt != IRS_MAX) begin
      irsCnt <= irsCnt + IRS_W'(1);
    end
  end
  assign intStable = (irsCnt == IRS_MAX);

  // ========================================================
  // loop selection and lock
  logic loopOn;
  logic refOk;
  logic relock;
  logic [LCK_W-1:0] lockCnt;
  assign loopOn = fllEnable || pllEnable;
  assign refOk = isInternal(curMode) ? intStable : extAvail;
  assign relock = commit && ((isInternal(reqMode) != isInternal(curMode)) ||
    (!isLowPower(reqMode) && (usesPll(reqMode) != pll_select_status)));

  // pll status follows the running loop, held in low power
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_select_status <= 1'b0;
    end else if (commit && !isLowPower(reqMode)) begin
      pll_select_status <= usesPll(reqMode);
    end
  end

  // lock counter restarts on reference or loop change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockCnt <= '0;
    end else if (!loopOn || !refOk || relock) begin
      lockCnt <= '0;
    end else if (lockCnt != LCK_MAX) begin
      lockCnt <= lockCnt + LCK_W'(1);
    end
  end
  assign lockQ = (lockCnt == LCK_MAX) && loopOn;

  // status register image
  always_comb begin
    statusReg = 8'h00;
    statusReg[`CMS_SC_LOCK] = lockQ;
    statusReg[`CMS_SC_PLL_SELECT_STATUS] = pll_select_status;
    statusReg[`CMS_SC_IREFST] = isInternal(curMode);
    statusReg[`CMS_SC_CLOCK_SOURCE_STATUS_HI:`CMS_SC_CLOCK_SOURCE_STATUS_LO] = srcOf(curMode);
    statusReg[`CMS_SC_OSCILLATOR_INITIALIZED] = oscillator_initialized;
  end

  // ========================================================
  // output and bus frequency
  logic [63:0] next_outFreq;
  logic [63:0] extDiv;
  assign extDiv = {32'h00000000, extRefFreq} >> refDiv;

  // frequency per mode
  always_comb begin
    unique case (curMode)
      MODE_LOOP_ENGAGED_INTERNAL: next_outFreq =
        ({32'h00000000, intRefFreq} << `CMS_FLL_SHIFT) >> busDiv;
      MODE_LOOP_ENGAGED_EXTERNAL: next_outFreq =
        (extDiv << `CMS_FLL_SHIFT) >> busDiv;
      MODE_PLL_ENGAGED_EXTERNAL: next_outFreq = (extDiv *
        {58'h0, pllMult, 2'h0}) >> busDiv;
      MODE_LOOP_BYPASSED_INTERNAL, MODE_LOW_POWER_INTERNAL: next_outFreq =
        {32'h00000000, intRefFreq} >> busDiv;
      MODE_LOOP_BYPASSED_EXTERNAL, MODE_PLL_BYPASSED_EXTERNAL,
      MODE_LOW_POWER_EXTERNAL: next_outFreq =
        {32'h00000000, extRefFreq} >> busDiv;
    endcase
  end

  // registered frequency outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      genOutFreq <= 32'h00000000;
      busFreq <= 32'h00000000;
    end else begin
      genOutFreq <= next_outFreq[31:0];
      busFreq <= {1'b0, genOutFreq[31:1]};
    end
  end

  // ========================================================
  // assertions
  sequence sBothHeld;
    awHeld && wHeld && !s_axi_bvalid;
  endsequence
  sequence sRespUp;
    s_axi_bvalid;
  endsequence

  a_write_resp: assert property (@(posedge clk) disable iff (sys_rst)
    sBothHeld |=> sRespUp)
    else $error("write response missing");
  a_reset_mode: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> curMode == MODE_LOOP_ENGAGED_INTERNAL)
    else $error("mode after reset wrong");
  a_first_exit: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(curMode) == MODE_LOOP_ENGAGED_INTERNAL &&
    curMode != MODE_LOOP_ENGAGED_INTERNAL) |-> curMode inside {
    MODE_LOOP_ENGAGED_EXTERNAL, MODE_LOOP_BYPASSED_EXTERNAL,
    MODE_LOOP_BYPASSED_INTERNAL})
    else $error("illegal exit from reset mode");
  a_fll_ext: assert property (@(posedge clk) disable iff (sys_rst)
    curMode == MODE_LOOP_ENGAGED_EXTERNAL |-> fllEnable &&
    statusReg[3:2] == 2'h0 && !statusReg[4])
    else $error("fll external path wrong");
  a_fbe_loop_on: assert property (@(posedge clk) disable iff (sys_rst)
    curMode == MODE_LOOP_BYPASSED_EXTERNAL |-> fllEnable &&
    statusReg[3:2] == 2'h2)
    else $error("bypassed fll not running");
  a_int_route: assert property (@(posedge clk) disable iff (sys_rst)
    curMode == MODE_LOOP_BYPASSED_INTERNAL |=>
    genOutFreq == ($past(intRefFreq) >> $past(busDiv)))
    else $error("internal route wrong");
  a_osc_done: assert property (@(posedge clk) disable iff (sys_rst)
    oscRun && oscCnt == OSC_MAX |=> oscillator_initialized)
    else $error("oscillator init missing");
  a_no_early: assert property (@(posedge clk) disable iff (sys_rst)
    curMode != $past(curMode) |-> $past(modeReady))
    else $error("switched to unavailable clock");
  a_bus_half: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> busFreq == ($past(genOutFreq) >> 1))
    else $error("bus frequency not half");
  a_lp_loops: assert property (@(posedge clk) disable iff (sys_rst)
    isLowPower(curMode) |-> !fllEnable && !pllEnable && !lockQ)
    else $error("loop on in low power");
  a_relock: assert property (@(posedge clk) disable iff (sys_rst)
    relock |=> !lockQ [*2])
    else $error("lock kept over reference change");
  a_iref_keep: assert property (@(posedge clk) disable iff (sys_rst)
    irefEnable |=> irsCnt != '0)
    else $error("internal reference stopped");
endmodule : clock_mode_sequencer
`default_nettype wire

/* File: testbench/cms_ext_src.sv */
// external clock source model facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module cms_ext_src (
  input wire logic clk,
  input wire logic srcOn,
  input wire logic [31:0] freqSet,
  output logic present,
  output logic [31:0] freq
);
  logic [3:0] warm = 4'h0;
  // ==========================================================
  // source settles some cycles after power-up, no frequency when off
  always_ff @(posedge clk) begin
    warm <= srcOn ? ((warm == 4'hF) ? warm : warm + 4'h1) : 4'h0;
    present <= srcOn && (warm == 4'hF);
    freq <= present ? freqSet : 32'h0;
  end
endmodule : cms_ext_src
`default_nettype wire

/* File: testbench/tb_top.sv */
// clock mode sequencer bench: modes, status and register bus
`include "cms_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cms_pkg::*;
  localparam logic [31:0] C1 = {28'h0, `CMS_OFF_CTRL_ONE};
  localparam logic [31:0] C2 = {28'h0, `CMS_OFF_CTRL_TWO};
  localparam logic [31:0] C3 = {28'h0, `CMS_OFF_CTRL_THREE};
  localparam logic [31:0] ST = {28'h0, `CMS_OFF_STATUS};
  logic clk = 1'b0, sys_rst = 1'b1, srcOn = 1'b0, present;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, extFreq = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata, rdVal, refFreq, genOut, busOut;
  logic [1:0] bresp, rresp, resp;
  cms_mode_e mode;
  int mismatches = 0, total_checks = 0, bd;
  logic [31:0] ext, intF;
  logic [3:0] strb = 4'hF;
  logic fllOn, pllOn, irOn, oscOn, oscHr, oscHg;

  always #2 clk = ~clk;

  clock_mode_sequencer #(.OSC_STARTUP_CYCLES(4), .LOCK_CYCLES(4),
    .IREF_STABLE_CYCLES(2)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .extRefPresent(present), .extRefFreq(refFreq),
    .intRefFreq(intF), .clockMode(mode), .genOutFreq(genOut),
    .busFreq(busOut), .fllEnable(fllOn), .pllEnable(pllOn),
    .intRefOn(irOn), .oscEnable(oscOn), .oscHighRange(oscHr),
    .oscHighGain(oscHg));

  cms_ext_src ext_u (.clk(clk), .srcOn(srcOn), .freqSet(extFreq),
    .present(present), .freq(refFreq));

  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic hang;
    mismatches++;
    $display("[FAIL] wait expected done seen timeout");
    report_and_stop();
  endtask : hang

  // expected output clock: kind 0 loop, 3 pll, else bypass
  function automatic logic [31:0] fexp(input logic [1:0] kind,
    input logic [31:0] f, input int rdv, vm, bdv);
    case (kind)
      2'h0: return ((f >> rdv) * 1024) >> bdv;
      2'h3: return ((f >> rdv) * (4 * vm)) >> bdv;
      default: return f >> bdv;
    endcase
  endfunction : fexp

  // ==========================================================
  // register bus master
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      rdVal = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rd

  task automatic poll(input logic [7:0] mask, val);
    for (int n = 0; n < 100; n++) begin
      rd(ST);
      if ((rdVal[7:0] & mask) == val) return;
    end
    hang();
  endtask : poll

  task automatic fchk(input logic [31:0] e);
    repeat (3) @(negedge clk);
    chk("output clock", genOut, e);
    chk("bus clock", busOut, e >> 1);
  endtask : fchk

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h8402DD23));
    ext = 32'h003D0900 + $urandom % 32'h000F4240;
    extFreq = ext;
    intF = 32'h00007A12 + $urandom % 32'h00001000;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(C1);
    chk("control one", rdVal, 32'h04);
    rd(C2);
    chk("control two", rdVal, 32'h40);
    rd(C3);
    chk("control three", rdVal, 32'h01);
    rd(ST);
    chk("reset status", rdVal & 32'hBF, 32'h10);
    chk("reset loops", {fllOn, pllOn, irOn}, 32'h5);
    fchk(fexp(2'h0, intF, 0, 0, 1));
    wr(32'h10, 8'hFF);
    chk("unmapped write", resp, 2'h2);
    strb <= 4'h0;
    wr(C3, 8'h40);
    strb <= 4'hF;
    rd(C3);
    chk("strobe off", rdVal, 32'h01);
    $display("test reset and map done");
    // external source absent: the switch must wait
    wr(C2, 8'h00);
    wr(C1, 8'hB8);
    repeat (20) @(posedge clk);
    rd(ST);
    chk("source held", rdVal & 32'h1C, 32'h10);
    srcOn <= 1'b1;
    poll(8'h1C, 8'h08);
    poll(8'h40, 8'h40);
    bd = $urandom % 4;
    wr(C2, {bd[1:0], 6'h00});
    fchk(fexp(2'h2, ext, 0, 0, bd));
    wr(C1, 8'h38);
    poll(8'h1C, 8'h00);
    fchk(fexp(2'h0, ext, 7, 0, bd));
    wr(C1, 8'hBA);
    poll(8'h1C, 8'h08);
    chk("internal kept on", irOn, 32'h1);
    wr(C2, 8'h0E);
    poll(8'h02, 8'h02);
    @(negedge clk);
    chk("low power", mode, MODE_LOW_POWER_EXTERNAL);
    chk("loops off", {fllOn, pllOn}, 32'h0);
    chk("crystal running", oscOn, 32'h1);
    wr(C2, 8'h36);
    poll(8'h42, 8'h42);
    chk("range and gain", {oscHr, oscHg}, 32'h3);
    $display("test loop bypassed done");
    // pll bypassed then engaged
    wr(C1, 8'h90);
    wr(C3, 8'h44);
    poll(8'h60, 8'h60);
    wr(C1, 8'h10);
    poll(8'h0C, 8'h0C);
    fchk(fexp(2'h3, ext, 2, 4, 0));
    chk("pll enabled", {fllOn, pllOn}, 32'h1);
    wr(C1, 8'h44);
    repeat (20) @(posedge clk);
    rd(ST);
    chk("no direct jump", rdVal & 32'h0C, 32'h0C);
    $display("test pll done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
